// ### pkg/pqs_pkg.sv
// package for the packet/queued dma sequencer: states, commands, frame carriers
package pqs_pkg;

  // data path width and limits
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned FRAME_MAX_BYTES = 8192;
  localparam int unsigned WORD_BYTES      = DATA_W / 8;
  localparam int unsigned FRAME_MAX_WORDS = FRAME_MAX_BYTES / WORD_BYTES;
  localparam int unsigned FIFO_DEPTH      = 32;
  localparam int unsigned LEN_W           = 12;
  localparam int unsigned FCNT_W          = 12;

  // command codes accepted on the start port
  typedef enum logic [1:0] {
    PQS_CMD_PKT_IN  = 2'h0,
    PQS_CMD_PKT_OUT = 2'h1,
    PQS_CMD_Q_READ  = 2'h2,
    PQS_CMD_NONE    = 2'h3
  } pqs_cmd_t;

  // frame kinds asked of the transport layer
  typedef enum logic [1:0] {
    PQS_FRM_DATA     = 2'h0,
    PQS_FRM_ACTIVATE = 2'h1,
    PQS_FRM_REGISTER = 2'h2,
    PQS_FRM_NONE     = 2'h3
  } pqs_frame_t;

  // sequencer states
  typedef enum logic [3:0] {
    DEVICE_IDLE_STATE         = 4'h0,
    PACKET_DMA_IN_STATE       = 4'h1,
    PACKET_SEND_DATA_STATE    = 4'h2,
    PACKET_DMA_OUT_STATE      = 4'h3,
    PACKET_ACTIVATE_STATE     = 4'h4,
    PACKET_RECEIVE_DATA_STATE = 4'h5,
    PACKET_SEND_STATUS_STATE  = 4'h6,
    PACKET_RELEASE_STATE      = 4'h7,
    QUEUED_READ_ENTRY_STATE   = 4'h8,
    QUEUED_SEND_DATA_STATE    = 4'h9,
    QUEUED_PREPARE_STATE      = 4'hA,
    QUEUED_SEND_STATUS_STATE  = 4'hB,
    QUEUED_RELEASE_STATE      = 4'hC
  } pqs_state_t;

  // frame-send request toward the transport layer
  typedef struct packed {
    pqs_frame_t            kind;
    logic                  int_flag;
    logic                  bus_release_flag;
    logic [LEN_W-1:0]      words;
  } pqs_txreq_t;

  // one data word of a frame
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              last;
  } pqs_beat_t;

  localparam int unsigned BEAT_W = $bits(pqs_beat_t);

endpackage : pqs_pkg

// ### src/pqs_fifo.sv
// synchronous valid/ready fifo with parameter width and depth
`timescale 1ns/1ps
`default_nettype none
module pqs_fifo #(
  parameter int unsigned WIDTH = 33,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  // full and empty come straight from the occupancy count
  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // pointer and count next values
  always_comb begin
    wr_d  = push ? wr_q + AW'(1) : wr_q;
    rd_d  = pop ? rd_q + AW'(1) : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset; contents are only read once counted in
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

endmodule : pqs_fifo
`default_nettype wire

// ### src/pqs_sequencer.sv
// command-layer sequencer for packet dma phases and queued dma read
`timescale 1ns/1ps
`default_nettype none

module pqs_sequencer
  import pqs_pkg::*;
#(
  parameter int unsigned DEPTH = pqs_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_b_i,
  // configuration
  input  wire logic                       queuing_en_i,
  input  wire logic                       release_int_en_i,
  // command start
  input  wire logic                       cmd_valid_i,
  input  wire pqs_pkg::pqs_cmd_t          cmd_i,
  input  wire logic [31:0]                cmd_words_i,
  input  wire logic                       abort_i,
  input  wire logic                       release_wanted_i,
  input  wire logic                       rx_room_i,
  output logic                            busy_o,
  output pqs_pkg::pqs_state_t             state_o,
  // outgoing data from the media side
  input  wire logic                       src_valid_i,
  output logic                            src_ready_o,
  input  wire logic [pqs_pkg::DATA_W-1:0] src_data_i,
  // received data toward the media side
  output logic                            rx_valid_o,
  input  wire logic                       rx_ready_i,
  output pqs_pkg::pqs_beat_t              rx_beat_o,
  // transport frame request
  output logic                            tx_req_o,
  output pqs_pkg::pqs_txreq_t             tx_info_o,
  input  wire logic                       tx_done_i,
  // transport data out
  output logic                            tx_valid_o,
  output pqs_pkg::pqs_beat_t              tx_beat_o,
  input  wire logic                       tx_ready_i,
  // transport data in
  input  wire logic                       trx_valid_i,
  input  wire pqs_pkg::pqs_beat_t         trx_beat_i
);
  import pqs_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH) + 1;

  pqs_state_t        st_q;
  pqs_state_t        st_d;
  logic [31:0]       left_q;
  logic [31:0]       left_d;
  logic [FCNT_W-1:0] fcnt_q;
  logic [FCNT_W-1:0] fcnt_d;
  logic [LEN_W-1:0]  flen_q;
  logic [LEN_W-1:0]  flen_d;
  logic [AW-1:0]     staged_q;
  logic [AW-1:0]     staged_d;
  logic              req_q;
  logic              req_d;
  pqs_txreq_t        info_q;
  pqs_txreq_t        info_d;
  logic              txv_q;
  logic              txv_d;
  pqs_beat_t         txb_q;
  pqs_beat_t         txb_d;
  logic              rxv_q;
  logic              rxv_d;
  pqs_beat_t         rxb_q;
  pqs_beat_t         rxb_d;
  logic              src_rdy_q;
  logic              src_rdy_d;

  // fifo wiring
  logic      f_in_ready;
  logic      f_out_valid;
  logic      f_out_ready;
  pqs_beat_t f_out;
  logic      f_push;
  logic      data_ready;
  logic      frame_beat;

  // smaller of remaining words and the largest frame
  function automatic logic [LEN_W-1:0] frame_words(input logic [31:0] left);
    logic [LEN_W-1:0] r;
    r = (left >= 32'(FRAME_MAX_WORDS)) ? LEN_W'(FRAME_MAX_WORDS) : left[LEN_W-1:0];
    return r;
  endfunction : frame_words

  // ready is registered from the next fill level, so the pin never waits on fifo logic
  assign f_push      = src_valid_i & src_rdy_q;

  pqs_fifo #(
    .WIDTH (BEAT_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_valid_i  (f_push),
    .in_ready_o  (f_in_ready),
    .in_data_i   ({src_data_i, 1'b0}),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready),
    .out_data_o  (f_out)
  );

  // a frame is ready once the fifo holds it whole, or is full
  assign data_ready = (left_q != '0) &&
                      ((32'(staged_q) >= 32'(frame_words(left_q))) ||
                       (32'(staged_q) >= 32'(DEPTH)));
  // one data beat leaves in send-data when the output register is free
  assign frame_beat = req_q && (info_q.kind == PQS_FRM_DATA) && (fcnt_q != '0) &&
                      f_out_valid && (!txv_q || tx_ready_i);
  assign f_out_ready = frame_beat;

  // sequencer next state, frame request and counters
  always_comb begin
    st_d     = st_q;
    left_d   = left_q;
    fcnt_d   = fcnt_q;
    flen_d   = flen_q;
    req_d    = req_q;
    info_d   = info_q;
    staged_d = staged_q + AW'(f_push & f_in_ready) - AW'(f_out_ready & f_out_valid);
    txv_d    = txv_q && !tx_ready_i;
    txb_d    = txb_q;
    rxv_d    = rxv_q && !rx_ready_i;
    rxb_d    = rxb_q;
    if (frame_beat) begin
      txv_d      = 1'b1;
      txb_d.data = f_out.data;
      txb_d.last = (fcnt_q == FCNT_W'(1));
      fcnt_d     = fcnt_q - FCNT_W'(1);
    end
    case (st_q)
      DEVICE_IDLE_STATE: begin
        if (cmd_valid_i) begin
          left_d = cmd_words_i;
          case (cmd_i)
            PQS_CMD_PKT_IN:  st_d = PACKET_DMA_IN_STATE;
            PQS_CMD_PKT_OUT: st_d = PACKET_DMA_OUT_STATE;
            PQS_CMD_Q_READ:  st_d = QUEUED_READ_ENTRY_STATE;
            default:         st_d = DEVICE_IDLE_STATE;
          endcase
        end
      end
      PACKET_DMA_IN_STATE: begin
        if (abort_i || left_q == '0) begin
          st_d = PACKET_SEND_STATUS_STATE;
        end else if (data_ready) begin
          st_d = PACKET_SEND_DATA_STATE;
        end else if (queuing_en_i) begin
          st_d = PACKET_RELEASE_STATE;
        end
      end
      PACKET_DMA_OUT_STATE: begin
        if (abort_i || left_q == '0) begin
          st_d = PACKET_SEND_STATUS_STATE;
        end else if (rx_room_i) begin
          st_d = PACKET_ACTIVATE_STATE;
        end else if (queuing_en_i) begin
          st_d = PACKET_RELEASE_STATE;
        end
      end
      QUEUED_READ_ENTRY_STATE: begin
        if (abort_i) begin
          st_d = QUEUED_SEND_STATUS_STATE;
        end else if (data_ready) begin
          st_d = QUEUED_SEND_DATA_STATE;
        end else if (release_wanted_i && queuing_en_i) begin
          st_d = QUEUED_RELEASE_STATE;
        end
      end
      QUEUED_PREPARE_STATE: begin
        // no release path here: data has started moving
        if (abort_i || left_q == '0) begin
          st_d = QUEUED_SEND_STATUS_STATE;
        end else if (data_ready) begin
          st_d = QUEUED_SEND_DATA_STATE;
        end
      end
      PACKET_RECEIVE_DATA_STATE: begin
        if (trx_valid_i && !rxv_d) begin
          rxv_d  = 1'b1;
          rxb_d  = trx_beat_i;
          left_d = (left_q != '0) ? left_q - 32'h1 : left_q;
          if (trx_beat_i.last) begin
            st_d = PACKET_DMA_OUT_STATE;
          end
        end
      end
      PACKET_SEND_DATA_STATE, PACKET_ACTIVATE_STATE, PACKET_SEND_STATUS_STATE,
      PACKET_RELEASE_STATE, QUEUED_SEND_DATA_STATE, QUEUED_SEND_STATUS_STATE,
      QUEUED_RELEASE_STATE: begin
        // request stays raised until transport says done
        if (!req_q) begin
          req_d                 = 1'b1;
          info_d.int_flag       = 1'b0;
          info_d.bus_release_flag = 1'b0;
          info_d.words          = '0;
          case (st_q)
            PACKET_SEND_DATA_STATE, QUEUED_SEND_DATA_STATE: begin
              info_d.kind  = PQS_FRM_DATA;
              info_d.words = frame_words(left_q);
              fcnt_d       = FCNT_W'(frame_words(left_q));
              flen_d       = frame_words(left_q);
            end
            PACKET_ACTIVATE_STATE: begin
              // the far side learns the expected frame length from the request
              info_d.kind  = PQS_FRM_ACTIVATE;
              info_d.words = frame_words(left_q);
            end
            PACKET_SEND_STATUS_STATE, QUEUED_SEND_STATUS_STATE: begin
              info_d.kind     = PQS_FRM_REGISTER;
              info_d.int_flag = 1'b1;
            end
            default: begin
              info_d.kind             = PQS_FRM_REGISTER;
              info_d.bus_release_flag = 1'b1;
              info_d.int_flag         = release_int_en_i;
            end
          endcase
        end else if (tx_done_i && (info_q.kind != PQS_FRM_DATA || fcnt_q == '0)) begin
          req_d = 1'b0;
          case (st_q)
            PACKET_SEND_DATA_STATE: st_d = PACKET_DMA_IN_STATE;
            QUEUED_SEND_DATA_STATE: st_d = QUEUED_PREPARE_STATE;
            PACKET_ACTIVATE_STATE:  st_d = PACKET_RECEIVE_DATA_STATE;
            default:                st_d = DEVICE_IDLE_STATE;
          endcase
          if (info_q.kind == PQS_FRM_DATA) begin
            left_d = left_q - 32'(flen_q);
          end
        end
      end
      default: st_d = DEVICE_IDLE_STATE;
    endcase
    // source ready for the next cycle: active command and room left after this cycle
    src_rdy_d = (st_d != DEVICE_IDLE_STATE) && (32'(staged_d) < 32'(DEPTH));
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q     <= DEVICE_IDLE_STATE;
      left_q   <= '0;
      fcnt_q   <= '0;
      flen_q   <= '0;
      staged_q <= '0;
      req_q    <= 1'b0;
      info_q   <= '{kind: PQS_FRM_NONE, int_flag: 1'b0, bus_release_flag: 1'b0, words: '0};
      txv_q    <= 1'b0;
      txb_q    <= '0;
      rxv_q    <= 1'b0;
      rxb_q    <= '0;
      src_rdy_q <= 1'b0;
    end else begin
      st_q     <= st_d;
      left_q   <= left_d;
      fcnt_q   <= fcnt_d;
      flen_q   <= flen_d;
      staged_q <= staged_d;
      req_q    <= req_d;
      info_q   <= info_d;
      txv_q    <= txv_d;
      txb_q    <= txb_d;
      rxv_q    <= rxv_d;
      rxb_q    <= rxb_d;
      src_rdy_q <= src_rdy_d;
    end
  end

  // status and registered outputs
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_o  <= 1'b0;
      state_o <= DEVICE_IDLE_STATE;
    end else begin
      busy_o  <= (st_d != DEVICE_IDLE_STATE);
      state_o <= st_d;
    end
  end

  assign tx_req_o   = req_q;
  assign tx_info_o  = info_q;
  assign tx_valid_o = txv_q;
  assign tx_beat_o  = txb_q;
  assign rx_valid_o = rxv_q;
  assign rx_beat_o  = rxb_q;
  assign src_ready_o = src_rdy_q;

endmodule : pqs_sequencer
`default_nettype wire

// ### tb/pqs_sequencer_monitor.sv
// assertion checker bound to the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module pqs_sequencer_monitor
  import pqs_pkg::*;
(
  // clock and reset
  input wire logic                clk_i,
  input wire logic                rst_b_i,
  // controls
  input wire logic                queuing_en_i,
  input wire logic                release_int_en_i,
  input wire logic                abort_i,
  // observed
  input wire logic                busy_o,
  input wire pqs_pkg::pqs_state_t state_o,
  input wire logic                tx_req_o,
  input wire pqs_pkg::pqs_txreq_t tx_info_o,
  input wire logic                tx_done_i
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // a request that completes this cycle
  wire logic fin = tx_req_o && tx_done_i;
  chk_req_holds: assert property (tx_req_o && !tx_done_i |=> tx_req_o && $stable(tx_info_o))
    else $error("request dropped or changed early");
  chk_req_clears: assert property (fin |=> !tx_req_o)
    else $error("request stands after completion");
  chk_frame_max: assert property (tx_req_o && tx_info_o.kind == PQS_FRM_DATA
    |-> tx_info_o.words inside {[1:FRAME_MAX_WORDS]})
    else $error("data frame size out of range");
  chk_status_int: assert property (tx_req_o && tx_info_o.kind == PQS_FRM_REGISTER
    && !tx_info_o.bus_release_flag |-> tx_info_o.int_flag)
    else $error("status frame without interrupt flag");
  chk_release_int: assert property (tx_req_o && tx_info_o.bus_release_flag
    |-> queuing_en_i && tx_info_o.int_flag == release_int_en_i)
    else $error("release frame flags wrong");
  chk_send_loop: assert property (fin && state_o == PACKET_SEND_DATA_STATE
    |=> state_o == PACKET_DMA_IN_STATE)
    else $error("send-data did not return to dma-in");
  chk_activate_next: assert property (fin && state_o == PACKET_ACTIVATE_STATE
    |=> state_o == PACKET_RECEIVE_DATA_STATE)
    else $error("activate did not lead to receive");
  chk_qsend_next: assert property (fin && state_o == QUEUED_SEND_DATA_STATE
    |=> state_o == QUEUED_PREPARE_STATE)
    else $error("queued send-data did not lead to prepare");
  chk_end_idle: assert property (fin && state_o inside {PACKET_SEND_STATUS_STATE,
    PACKET_RELEASE_STATE, QUEUED_SEND_STATUS_STATE, QUEUED_RELEASE_STATE}
    |=> state_o == DEVICE_IDLE_STATE && !busy_o)
    else $error("no return to idle after final frame");
  chk_entry_abort: assert property (state_o == QUEUED_READ_ENTRY_STATE && abort_i
    |=> state_o == QUEUED_SEND_STATUS_STATE)
    else $error("abort in queued entry not honoured");
  chk_no_release: assert property (state_o inside {QUEUED_SEND_DATA_STATE, QUEUED_PREPARE_STATE}
    |=> state_o inside {QUEUED_SEND_DATA_STATE, QUEUED_PREPARE_STATE,
    QUEUED_SEND_STATUS_STATE})
    else $error("queued transfer left its data loop");
  // main scenarios reached
  cov_release: cover property (fin && tx_info_o.bus_release_flag && tx_info_o.int_flag);
  cov_activate: cover property (fin && state_o == PACKET_ACTIVATE_STATE);
  cov_requeue: cover property (state_o == QUEUED_PREPARE_STATE ##1 state_o == QUEUED_SEND_DATA_STATE);
endmodule : pqs_sequencer_monitor
bind pqs_sequencer pqs_sequencer_monitor i_mon (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .queuing_en_i(queuing_en_i), .release_int_en_i(release_int_en_i), .abort_i(abort_i),
  .busy_o(busy_o), .state_o(state_o), .tx_req_o(tx_req_o), .tx_info_o(tx_info_o),
  .tx_done_i(tx_done_i));
`default_nettype wire

// ### tb/pqs_transport_model.sv
// behavioural transport layer facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module pqs_transport_model
  import pqs_pkg::*;
(
  // clock, reset and pacing
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire logic                slow_i,
  // frame requests
  input  wire logic                tx_req_i,
  input  wire pqs_pkg::pqs_txreq_t tx_info_i,
  output logic                     tx_done_o,
  // data words both ways
  input  wire logic                tx_valid_i,
  input  wire pqs_pkg::pqs_beat_t  tx_beat_i,
  output logic                     tx_ready_o,
  output logic                     trx_valid_o,
  output pqs_pkg::pqs_beat_t       trx_beat_o,
  // what was seen
  output logic [31:0]              words_o,
  output logic [31:0]              last_data_o,
  output pqs_pkg::pqs_txreq_t      reg_info_o
);
  logic [11:0] n;
  logic        got;
  // completion pulse, then a spare edge so the dropped request is seen
  task automatic done_pulse();
    tx_done_o <= 1'h1;
    @(posedge clk_i);
    tx_done_o <= 1'h0;
    @(posedge clk_i);
  endtask : done_pulse
  // one request at a time; a data frame is taken whole, up to its last word, before done is pulsed
  initial begin
    {tx_done_o, tx_ready_o, trx_valid_o} = 3'h0;
    trx_beat_o = '0;
    words_o = '0;
    last_data_o = '0;
    reg_info_o = '0;
    forever begin
      @(posedge clk_i);
      if (rst_b_i && tx_req_i) begin
        n = tx_info_i.words;
        case (tx_info_i.kind)
          PQS_FRM_DATA: begin
            got = 1'h0;
            tx_ready_o <= 1'h1;
            while (!got) begin
              @(posedge clk_i);
              if (tx_valid_i && tx_ready_o) begin
                words_o <= words_o + 1;
                last_data_o <= tx_beat_i.data;
                got = tx_beat_i.last;
              end
              // slow pacing stalls every other cycle
              tx_ready_o <= !got && !(slow_i && tx_ready_o);
            end
            done_pulse();
          end
          PQS_FRM_ACTIVATE: begin
            done_pulse();
            for (int i = 0; i < n; i++) begin
              trx_valid_o <= 1'h1;
              trx_beat_o <= '{data: 32'(i), last: (i == n - 1)};
              @(posedge clk_i);
            end
            trx_valid_o <= 1'h0;
            trx_beat_o.data <= ~trx_beat_o.data; // idle line never repeats a word
          end
          PQS_FRM_REGISTER: begin
            reg_info_o <= tx_info_i;
            done_pulse();
          end
          default: ;
        endcase
      end
    end
  end
endmodule : pqs_transport_model
`default_nettype wire

// ### tb/pqs_sequencer_test.sv
// self-checking bench for the packet and queued dma sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin fails++; \
  $display("FAIL %s exp %0h got %0h", nm, e, s); end end
module pqs_sequencer_test;
  import pqs_pkg::*;
  // one command: cfg is {queuing, rel int, rel wanted, room, abort}
  typedef struct packed {
    pqs_cmd_t cmd; logic [11:0] n; logic [11:0] feed; logic [4:0] cfg;
    logic [11:0] exp_n; logic [1:0] exp_f;
  } pqs_row_t;
  localparam pqs_row_t ROWS [10] = '{
    '{PQS_CMD_PKT_IN, 12'h004, 12'h004, 5'h02, 12'h004, 2'h2},
    '{PQS_CMD_Q_READ, 12'h801, 12'h801, 5'h02, 12'h801, 2'h2},
    '{PQS_CMD_PKT_OUT, 12'h003, 12'h000, 5'h02, 12'h003, 2'h2},
    '{PQS_CMD_Q_READ, 12'h028, 12'h028, 5'h02, 12'h028, 2'h2},
    '{PQS_CMD_Q_READ, 12'h008, 12'h000, 5'h1C, 12'h000, 2'h3},
    '{PQS_CMD_Q_READ, 12'h008, 12'h000, 5'h14, 12'h000, 2'h1},
    '{PQS_CMD_PKT_IN, 12'h008, 12'h000, 5'h18, 12'h000, 2'h3},
    '{PQS_CMD_PKT_OUT, 12'h008, 12'h000, 5'h10, 12'h000, 2'h1},
    '{PQS_CMD_Q_READ, 12'h008, 12'h000, 5'h03, 12'h000, 2'h2},
    '{PQS_CMD_PKT_OUT, 12'h008, 12'h000, 5'h03, 12'h000, 2'h2}};
  logic clk_i = 1'h0, rst_b_i = 1'h0, slow = 1'h0;
  logic queuing_en_i, release_int_en_i, cmd_valid_i, abort_i, release_wanted_i, rx_room_i;
  logic busy_o, src_valid_i, src_ready_o, rx_valid_o, tx_req_o, tx_done_i;
  logic tx_valid_o, tx_ready_i, trx_valid_i, rx_last;
  pqs_cmd_t cmd_i;
  pqs_state_t state_o;
  pqs_beat_t rx_beat_o, tx_beat_o, trx_beat_i;
  pqs_txreq_t tx_info_o, reg_info;
  logic [31:0] cmd_words_i, src_data_i, words_n, last_data, fed, feed_n, w0, r0, rx_dat;
  int fails = 0, samples_checked = 0, cyc = 0, rx_n = 0;
  pqs_sequencer i_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .queuing_en_i(queuing_en_i),
    .release_int_en_i(release_int_en_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
    .cmd_words_i(cmd_words_i), .abort_i(abort_i), .release_wanted_i(release_wanted_i),
    .rx_room_i(rx_room_i), .busy_o(busy_o), .state_o(state_o), .src_valid_i(src_valid_i),
    .src_ready_o(src_ready_o), .src_data_i(src_data_i), .rx_valid_o(rx_valid_o),
    .rx_ready_i(1'h1), .rx_beat_o(rx_beat_o), .tx_req_o(tx_req_o), .tx_info_o(tx_info_o),
    .tx_done_i(tx_done_i), .tx_valid_o(tx_valid_o), .tx_beat_o(tx_beat_o),
    .tx_ready_i(tx_ready_i), .trx_valid_i(trx_valid_i), .trx_beat_i(trx_beat_i));
  pqs_transport_model i_far (.clk_i(clk_i), .rst_b_i(rst_b_i), .slow_i(slow),
    .tx_req_i(tx_req_o), .tx_info_i(tx_info_o), .tx_done_o(tx_done_i),
    .tx_valid_i(tx_valid_o), .tx_beat_i(tx_beat_o), .tx_ready_o(tx_ready_i),
    .trx_valid_o(trx_valid_i), .trx_beat_o(trx_beat_i), .words_o(words_n),
    .last_data_o(last_data), .reg_info_o(reg_info));
  always #2 clk_i = ~clk_i;
  // media source counts words taken; received words are counted at the sink
  always @(posedge clk_i) begin
    if (src_valid_i && src_ready_o) fed <= fed + 1;
    if (rx_valid_o) begin
      rx_n <= rx_n + 1;
      rx_last <= rx_beat_o.last;
      rx_dat <= rx_beat_o.data;
    end
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      report_and_stop();
    end
  end
  always @(negedge clk_i) begin
    src_valid_i <= fed < feed_n;
    src_data_i <= fed;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic launch(input pqs_row_t r);
    @(negedge clk_i);
    w0 = words_n;
    r0 = rx_n;
    fed = '0;
    feed_n = 32'(r.feed);
    {queuing_en_i, release_int_en_i, release_wanted_i, rx_room_i, abort_i} = r.cfg;
    cmd_i = r.cmd;
    cmd_words_i = 32'(r.n);
    cmd_valid_i = 1'h1;
    @(negedge clk_i);
    cmd_valid_i = 1'h0;
  endtask : launch
  task automatic finish(input pqs_row_t r);
    logic [31:0] seen;
    for (int k = 0; k < 9000 && busy_o !== 1'h0; k++) @(negedge clk_i);
    seen = (r.cmd == PQS_CMD_PKT_OUT) ? rx_n - r0 : words_n - w0;
    `CHK("busy", 1'h0, busy_o)
    `CHK("words", 32'(r.exp_n), seen)
    `CHK("flags", r.exp_f, {reg_info.int_flag, reg_info.bus_release_flag})
    if (r.exp_n != 0 && r.cmd != PQS_CMD_PKT_OUT) `CHK("tail", 32'(r.exp_n - 1), last_data)
    if (r.exp_n != 0 && r.cmd == PQS_CMD_PKT_OUT) `CHK("rxlast", 1'h1, rx_last)
    if (r.exp_n != 0 && r.cmd == PQS_CMD_PKT_OUT) `CHK("rxdata", 32'(r.exp_n - 1), rx_dat)
  endtask : finish
  // reset, table of commands, then stalled entry states and a mid-run reset
  initial begin
    {queuing_en_i, release_int_en_i, cmd_valid_i, abort_i, release_wanted_i} = 5'h00;
    {rx_room_i, src_valid_i, fed, feed_n, rx_last} = '0;
    cmd_i = PQS_CMD_NONE;
    cmd_words_i = '0;
    src_data_i = '0;
    repeat (12) @(negedge clk_i);
    `CHK("rst kind", PQS_FRM_NONE, tx_info_o.kind)
    rst_b_i = 1'h1;
    foreach (ROWS[i]) begin
      slow = i[0];
      launch(ROWS[i]);
      finish(ROWS[i]);
    end
    launch('{PQS_CMD_PKT_IN, 12'h004, 12'h000, 5'h02, 12'h004, 2'h2});
    repeat (40) @(negedge clk_i);
    `CHK("held in", PACKET_DMA_IN_STATE, state_o)
    feed_n = 32'h4;
    finish('{PQS_CMD_PKT_IN, 12'h004, 12'h004, 5'h02, 12'h004, 2'h2});
    launch('{PQS_CMD_Q_READ, 12'h004, 12'h000, 5'h10, 12'h000, 2'h2});
    repeat (40) @(negedge clk_i);
    `CHK("held entry", QUEUED_READ_ENTRY_STATE, state_o)
    rst_b_i = 1'h0;
    @(negedge clk_i);
    `CHK("rst state", DEVICE_IDLE_STATE, state_o)
    `CHK("rst req", 1'h0, tx_req_o)
    rst_b_i = 1'h1;
    launch(ROWS[3]);
    finish(ROWS[3]);
    // an unused command code must leave the sequencer idle
    launch('{PQS_CMD_NONE, 12'h004, 12'h000, 5'h02, 12'h000, 2'h2});
    `CHK("none cmd", 1'h0, busy_o)
    report_and_stop();
  end
endmodule : pqs_sequencer_test
`default_nettype wire
